/* File: ssap_top.v */
// Serial peripheral slave port with an AHB-Lite register interface.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "ssap_defines.vh"
// Function
// R1 - Port works only as slave; clock and inbound data come from master.
// R2 - Master keeps the serial clock at or below 5 Mb/s.
// R3 - Mode 0: clock idles low, data sampled on the rising edge.
// R4 - Every byte travels most significant bit first.
// R5 - Master pulls select low to address this port.
// R6 - Outbound bits leave on master-in at the master's clock rate.
// R7 - System tri-states master-in externally when select is high.
// R8 - Attention driven low while outbound data is queued, never tri-stated.
// R9 - Only unescaped API mode 1 framing; API mode setting ignored here.
// R10 - Transfers are full duplex; filler bytes are sent and discarded.
// R11 - Both directions may carry valid data overlapping in time.
// R12 - Input pull-ups enabled by default, disabled by configuration.
// R13 - Port inactive until first select low, then active until reset.
// R14 - Port enabled only when all four pin functions equal one.
// R15 - Holding transmit-out low during reset forces the port into use.
// R16 - Select rising mid-byte drops the partial byte and counter.
module ssap_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        spi_clk,
  input  wire        chip_select_low,
  input  wire        spi_mosi,
  output reg         spi_miso,
  output reg         spi_miso_oe,
  output reg         data_pending_alert_n,
  output reg         pullup_en,
  input  wire        uart_txout_pin
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [2:0] pins_s;
  wire       clk_s;
  wire       sel_n_s;
  wire       mosi_s;
  reg        clk_d1_q;
  reg        sel_d1_q;
  reg        force_q;
  reg        strap_done_q;
  ssap_sync #(.W(3)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({spi_clk, ~chip_select_low, spi_mosi}),
    .rst_val (3'h0),
    .dout    (pins_s)
  );
  assign clk_s   = pins_s[2];
  // Select travels inverted so a cleared synchroniser reads as deselected.
  assign sel_n_s = ~pins_s[1];
  assign mosi_s  = pins_s[0];
  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  reg        pullup_dis_q;
  reg [1:0]  api_mode_q;
  reg [19:0] pinfn_q;
  reg        active_q;
  reg        rx_ovf_q;
  reg [8:0]  rxbuf_q;
  wire       enabled;
  // Each four-bit field holds one pin function; peripheral code is one.
  function is_periph;
    input [3:0] fn;
    begin
      is_periph = (fn == `SSAP_PINFN_PERIPH);
    end
  endfunction
  assign enabled = (is_periph(pinfn_q[3:0]) & is_periph(pinfn_q[7:4]) &
                    is_periph(pinfn_q[11:8]) &
                    is_periph(pinfn_q[15:12])) | force_q; // R14 R15
  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  reg        ph_wr_q;
  reg        ph_rd_q;
  reg [`SSAP_AW-1:0] ph_addr_q;
  wire       take;
  wire       tx_in_ready;
  wire       tx_out_valid;
  wire [7:0] tx_out_data;
  reg        tx_pop;
  wire       tx_push;
  assign take    = hsel & hready & (htrans == `SSAP_HTRANS_NSEQ);
  assign tx_push = ph_wr_q & (ph_addr_q == `SSAP_ADDR_TXDATA) & tx_in_ready;
  wire rx_rd = ph_rd_q & (ph_addr_q == `SSAP_ADDR_RXDATA);
  wire rx_got;
  wire [7:0] rx_byte;
  function [31:0] rd_mux;
    input [`SSAP_AW-1:0] a;
    input [31:0] ctrl;
    input [31:0] stat;
    input [31:0] rx;
    input [31:0] fn;
    begin
      case (a)
        `SSAP_ADDR_CTRL:   rd_mux = ctrl;
        `SSAP_ADDR_STATUS: rd_mux = stat;
        `SSAP_ADDR_RXDATA: rd_mux = rx;
        `SSAP_ADDR_PINFN:  rd_mux = fn;
        default:           rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_q      <= 1'b0;
      ph_rd_q      <= 1'b0;
      ph_addr_q    <= {`SSAP_AW{1'b0}};
      hrdata       <= 32'h0000_0000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      pullup_dis_q <= 1'b0;
      api_mode_q   <= `SSAP_API_RESET;
      pinfn_q      <= `SSAP_PINFN_RESET;
      pullup_en    <= 1'b1;
    end else begin
      ph_wr_q   <= take & hwrite;
      ph_rd_q   <= take & ~hwrite;
      ph_addr_q <= haddr[`SSAP_AW-1:0];
      // Read data is prepared in the address phase; no wait states.
      if (take && !hwrite) begin
        hrdata <= rd_mux(haddr[`SSAP_AW-1:0],
                  {29'h0, api_mode_q, pullup_dis_q},
                  {25'h0, force_q, rx_ovf_q, ~tx_out_valid,
                   rxbuf_q[8], ~tx_in_ready, enabled, active_q},
                  {23'h0, rxbuf_q}, {12'h0, pinfn_q});
      end
      if (ph_wr_q && ph_addr_q == `SSAP_ADDR_CTRL) begin
        pullup_dis_q <= hwdata[`SSAP_CTRL_PULLUP_DIS];
        // Stored for software only; framing on this port never changes.
        api_mode_q   <= hwdata[`SSAP_CTRL_API_MODE]; // R9
      end
      if (ph_wr_q && ph_addr_q == `SSAP_ADDR_PINFN) begin
        pinfn_q <= hwdata[19:0];
      end
      pullup_en <= ~pullup_dis_q; // R12
    end
  end
  // ****************************************************************
  // Transmit FIFO
  // ****************************************************************
  ssap_fifo #(
    .WIDTH (`SSAP_BYTE_W),
    .DEPTH (`SSAP_FIFO_DEPTH),
    .AW    (`SSAP_FIFO_AW)
  ) u_txfifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .flush     (1'b0),
    .in_valid  (ph_wr_q & (ph_addr_q == `SSAP_ADDR_TXDATA)),
    .in_ready  (tx_in_ready),
    .in_data   (hwdata[7:0]),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_out_data)
  );
  // ****************************************************************
  // Serial engine
  // ****************************************************************
  reg [2:0] bit_q;
  reg [7:0] sh_in_q;
  reg [7:0] sh_out_q;
  reg       byte_real_q;
  wire      rise = clk_s & ~clk_d1_q;
  wire      fall = ~clk_s & clk_d1_q;
  wire      sel  = ~sel_n_s & active_q;
  assign rx_got  = sel & rise & (bit_q == `SSAP_BIT_LAST);
  assign rx_byte = {sh_in_q[6:0], mosi_s};
  always @* begin
    tx_pop = 1'b0;
    if (sel && fall && bit_q == 3'h0 && tx_out_valid) begin
      tx_pop = 1'b1;
    end
    if (!sel && bit_q == 3'h0 && !byte_real_q && enabled && tx_out_valid) begin
      tx_pop = 1'b1;
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_d1_q     <= 1'b0;
      sel_d1_q     <= 1'b1;
      force_q      <= 1'b0;
      strap_done_q <= 1'b0;
      active_q     <= 1'b0;
      bit_q        <= 3'h0;
      sh_in_q      <= 8'h00;
      sh_out_q     <= `SSAP_FILLER;
      byte_real_q  <= 1'b0;
      rxbuf_q      <= 9'h000;
      rx_ovf_q     <= 1'b0;
      spi_miso     <= 1'b1;
      spi_miso_oe  <= 1'b0;
      data_pending_alert_n <= 1'b1;
    end else begin
      clk_d1_q <= clk_s;
      sel_d1_q <= sel_n_s;
      // Strap is caught once just after reset release.
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        force_q      <= ~uart_txout_pin; // R15
      end
      if (enabled && !sel_n_s) begin
        active_q <= 1'b1; // R13
      end
      if (!sel) begin
        bit_q       <= 3'h0; // R16
        sh_in_q     <= 8'h00;
        spi_miso_oe <= 1'b0; // R16
        // A cut byte is lost; the next frame starts on a fresh byte.
        if (bit_q != 3'h0) begin
          sh_out_q    <= `SSAP_FILLER; // R16
          byte_real_q <= 1'b0;
        end else if (tx_out_valid && !byte_real_q && enabled) begin
          // Preload so bit 7 is on the line before the first rise.
          sh_out_q    <= tx_out_data;
          byte_real_q <= 1'b1;
        end
      end else begin
        spi_miso_oe <= 1'b1; // R1
        if (rise) begin
          sh_in_q <= rx_byte; // R3 R4
          bit_q   <= bit_q + 3'h1;
        end
        if (fall) begin
          if (bit_q == 3'h0) begin
            sh_out_q    <= tx_out_valid ? tx_out_data : `SSAP_FILLER; // R10
            byte_real_q <= tx_out_valid;
          end else begin
            sh_out_q <= {sh_out_q[6:0], 1'b1}; // R4 R6
          end
        end
      end
      // The next bit goes out with the shift to save a cycle of latency.
      if (sel && fall) begin
        if (bit_q == 3'h0) begin
          spi_miso <= tx_out_valid ? tx_out_data[7] : `SSAP_FILLER_MSB; // R6
        end else begin
          spi_miso <= sh_out_q[6]; // R6
        end
      end else begin
        spi_miso <= sh_out_q[7];
      end
      // Whole bytes only; the byte is offered to software as is.
      if (rx_got) begin
        rxbuf_q <= {1'b1, rx_byte}; // R10 R11
        if (rxbuf_q[8] && !rx_rd) begin
          rx_ovf_q <= 1'b1;
        end
      end else if (rx_rd) begin
        rxbuf_q[8] <= 1'b0;
      end
      if (ph_wr_q && ph_addr_q == `SSAP_ADDR_STATUS &&
          hwdata[`SSAP_ST_RX_OVF] && !(rx_got && rxbuf_q[8])) begin
        rx_ovf_q <= 1'b0;
      end
      // Low while any queued byte has not fully left on the wire.
      data_pending_alert_n <= ~(tx_out_valid | byte_real_q); // R8
      if (sel && rise && bit_q == `SSAP_BIT_LAST) begin
        byte_real_q <= 1'b0;
      end
    end
  end
endmodule

/* File: ssap_defines.vh */
// Constants for the serial peripheral slave port.
`ifndef SSAP_DEFINES_VH
`define SSAP_DEFINES_VH
// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define SSAP_ADDR_CTRL   12'h000
`define SSAP_ADDR_STATUS 12'h004
`define SSAP_ADDR_TXDATA 12'h008
`define SSAP_ADDR_RXDATA 12'h00C
`define SSAP_ADDR_PINFN  12'h010
`define SSAP_AW          12
// ****************************************************************
// Field positions
// ****************************************************************
`define SSAP_CTRL_PULLUP_DIS 0
`define SSAP_CTRL_API_MODE   2:1
`define SSAP_ST_ACTIVE       0
`define SSAP_ST_ENABLED      1
`define SSAP_ST_TX_FULL      2
`define SSAP_ST_RX_VALID     3
`define SSAP_ST_TX_EMPTY     4
`define SSAP_ST_RX_OVF       5
`define SSAP_ST_FORCED       6
`define SSAP_RX_VALID_BIT    8
// ****************************************************************
// Reset values and codes
// ****************************************************************
`define SSAP_PINFN_RESET  20'h11111
`define SSAP_PINFN_PERIPH 4'h1
`define SSAP_API_RESET    2'h0
`define SSAP_FILLER       8'hFF
`define SSAP_FILLER_MSB   1'b1
`define SSAP_BIT_LAST     3'h7
`define SSAP_BYTE_W       8
`define SSAP_FIFO_DEPTH   8
`define SSAP_FIFO_AW      3
`define SSAP_HTRANS_NSEQ  2'h2
`endif

/* File: ssap_sync.v */
// Two-stage synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
module ssap_sync #(
  parameter W = 4
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire [W-1:0] din,
  input  wire [W-1:0] rst_val,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q;
  // The reset value is fixed at all zeros; the rst_val input is not used.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

/* File: ssap_fifo.v */
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ssap_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  integer         i;
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else if (flush) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

/* File: ssap_top_asserts.sv */
// Concurrent checks on the ports of the serial slave port.
`timescale 1ns/1ps
module ssap_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        chip_select_low,
  input wire        spi_miso,
  input wire        spi_miso_oe,
  input wire        data_pending_alert_n,
  input wire        pullup_en
);
  reg seen_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      seen_q <= 1'b0;
    else if (!chip_select_low)
      seen_q <= 1'b1;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  tx_alert_a: assert property (hsel && hready && htrans == 2'h2 && hwrite
    && haddr[11:0] == 12'h008 |-> ##[2:4] !data_pending_alert_n)
    else $error("queued byte raised no alert");
  alert_hold_a: assert property (chip_select_low [*8]
    |-> !$rose(data_pending_alert_n))
    else $error("alert released without the master clocking");
  oe_rise_a: assert property ($rose(spi_miso_oe)
    |-> !chip_select_low && $past(!chip_select_low))
    else $error("master-in driven without select");
  oe_drop_a: assert property ($rose(chip_select_low)
    |-> ##[1:5] !spi_miso_oe)
    else $error("master-in still driven after deselect");
  idle_port_a: assert property (!seen_q |-> !spi_miso_oe)
    else $error("port active before first select");
  filler_out_a: assert property (spi_miso_oe && data_pending_alert_n
    && $past(data_pending_alert_n, 4) |-> spi_miso)
    else $error("filler bit not high");
  pullup_rst_a: assert property ($rose(hresetn) |-> pullup_en)
    else $error("pull-ups off after reset");
endmodule
bind ssap_top ssap_chk u_ssap_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .chip_select_low(chip_select_low),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
  .data_pending_alert_n(data_pending_alert_n), .pullup_en(pullup_en)
);

/* File: ssap_spi_master.sv */
// Behavioural host master for the serial slave port.
`timescale 1ns/1ps
module ssap_spi_master #(
  parameter HALF_NS = 100
) (
  output reg  spi_clk,
  output reg  chip_select_low,
  output reg  spi_mosi,
  input  wire spi_miso
);
  initial begin
    spi_clk = 1'b0;
    chip_select_low = 1'b1;
    spi_mosi = 1'b1;
  end
  // The clock stands low between frames and the released data line rests
  // high, as the pull-ups leave it.
  task xfer(input [7:0] tx, input integer nbits, output [7:0] rx);
    integer i;
    begin
      // Keep link edges away from the slave's clock edges.
      #5;
      chip_select_low = 1'b0;
      #(2 * HALF_NS);
      for (i = 7; i > 7 - nbits; i = i - 1) begin
        spi_mosi = tx[i];
        #HALF_NS;
        spi_clk = 1'b1;
        rx[i] = spi_miso;
        #HALF_NS;
        spi_clk = 1'b0;
      end
      #(2 * HALF_NS);
      chip_select_low = 1'b1;
      spi_mosi = 1'b1;
      #(2 * HALF_NS);
    end
  endtask
endmodule

/* File: test_spi_slave_api_port.sv */
// Self-checking bench for the serial slave port.
`timescale 1ns/1ps
`include "ssap_defines.vh"
module test_spi_slave_api_port;
  reg         hclk, hresetn, hsel, hwrite;
  reg  [31:0] haddr, hwdata;
  reg  [1:0]  htrans;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, spi_clk, chip_select_low, spi_mosi;
  wire        spi_miso, spi_miso_oe, data_pending_alert_n, pullup_en;
  wire        spi_miso_line;
  // External tri-state with pull-up on the shared master-in line.
  assign spi_miso_line = spi_miso_oe ? spi_miso : 1'b1;
  integer     bad_count, samples_checked, i;
  reg  [7:0]  rx;
  ssap_top u_ssap_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .spi_clk(spi_clk), .chip_select_low(chip_select_low),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .data_pending_alert_n(data_pending_alert_n), .pullup_en(pullup_en),
    .uart_txout_pin(1'b1));
  ssap_spi_master u_ssap_spi_master (
    .spi_clk(spi_clk), .chip_select_low(chip_select_low),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso_line));
  task end_sim;
    begin
      if (bad_count == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // A wait that runs out ends the run rather than hanging it.
  task wt;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 50) begin
        @(posedge hclk);
        n = n + 1;
      end
      if (n >= 50) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0t bus wait timed out", $time);
        end_sim;
      end
    end
  endtask
  task bus(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      hwrite <= wr;
      htrans <= `SSAP_HTRANS_NSEQ;
      haddr <= {20'h0, a};
      wt;
      hsel <= 1'b0;
      htrans <= 2'h0;
      if (wr)
        hwdata <= d;
      wt;
      if (!wr)
        chk(hrdata, d);
    end
  endtask
  task xf(input [7:0] tx, input [7:0] exp);
    begin
      u_ssap_spi_master.xfer(tx, 8, rx);
      chk({24'h0, rx}, {24'h0, exp});
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    bad_count = 0;
    samples_checked = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, `SSAP_ADDR_PINFN, 32'h11111);
    bus(0, `SSAP_ADDR_CTRL, 32'h0);
    chk({31'h0, pullup_en}, 32'h1);
    chk({31'h0, spi_miso_oe}, 32'h0);
    bus(0, 12'h020, 32'h0);
    for (i = 0; i < 10; i = i + 1)
      bus(1, `SSAP_ADDR_TXDATA, 32'hA0 + i);
    bus(0, `SSAP_ADDR_STATUS, 32'h6);
    chk({31'h0, data_pending_alert_n}, 32'h0);
    for (i = 0; i < 9; i = i + 1) begin
      xf(8'h30 + i[7:0], 8'hA0 + i[7:0]);
      bus(0, `SSAP_ADDR_RXDATA, 32'h130 + i);
    end
    chk({31'h0, data_pending_alert_n}, 32'h1);
    xf(8'h7E, 8'hFF);
    bus(0, `SSAP_ADDR_RXDATA, 32'h17E);
    u_ssap_spi_master.xfer(8'h0F, 4, rx);
    xf(8'h55, 8'hFF);
    bus(0, `SSAP_ADDR_RXDATA, 32'h155);
    bus(0, `SSAP_ADDR_STATUS, 32'h13);
    bus(1, `SSAP_ADDR_CTRL, 32'h5);
    bus(0, `SSAP_ADDR_CTRL, 32'h5);
    chk({31'h0, pullup_en}, 32'h0);
    bus(1, `SSAP_ADDR_TXDATA, 32'h5A);
    xf(8'h7E, 8'h5A);
    bus(1, `SSAP_ADDR_CTRL, 32'h0);
    bus(1, `SSAP_ADDR_PINFN, 32'h11110);
    bus(0, `SSAP_ADDR_STATUS, 32'h19);
    end_sim;
  end
endmodule
